// >>> core/prx_params.svh
`ifndef PRX_PARAMS_SVH
`define PRX_PARAMS_SVH
// ****************************************
// register offsets
// ****************************************
`define PRX_A_ENABLE   5'h00
`define PRX_A_ITIME    5'h02
`define PRX_A_WAIT_INTERVAL    5'h03
`define PRX_A_LOWL     5'h08
`define PRX_A_LOWH     5'h09
`define PRX_A_HIGHL    5'h0a
`define PRX_A_HIGHH    5'h0b
`define PRX_A_PERSISTENCE_FILTER     5'h0c
`define PRX_A_SETUP    5'h0d
`define PRX_A_PULSE    5'h0e
`define PRX_A_GAIN     5'h0f
`define PRX_A_PULSE_DURATION   5'h10
`define PRX_A_PART     5'h12
`define PRX_A_STATUS   5'h13
`define PRX_A_RESL     5'h18
`define PRX_A_RESH     5'h19
`define PRX_A_BIAS     5'h1e
// ****************************************
// command byte fields and codes
// ****************************************
`define PRX_CMD_SEL    7
`define PRX_TYPE_REP   2'h0
`define PRX_TYPE_AUTO  2'h1
`define PRX_TYPE_SF    2'h3
`define PRX_SF_ICLR    5'h05
`define PRX_I2C_ADDR   7'h39
// ****************************************
// field positions and reset values
// ****************************************
`define PRX_ST_IRQ     5
`define PRX_ST_VALID   0
`define PRX_DRIVE_MSB  7
`define PRX_DRIVE_LSB  6
`define PRX_WLONG      1
`define PRX_RST_TIME   8'hff
`define PRX_RST_ZERO   8'h00
// ****************************************
// timing
// ****************************************
`define PRX_CLK_NS       40
`define PRX_WAIT_UNIT_NS 3330000
`define PRX_WAIT_UNIT_CYC ((`PRX_WAIT_UNIT_NS + `PRX_CLK_NS - 1) / `PRX_CLK_NS)
`define PRX_WLONG_MULT   12
`endif

// >>> core/prx_pkg.sv
package prx_pkg;
	// enable register layout
	typedef struct packed {
		logic rsv7;
		logic sleep_after_irq;
		logic prox_irq_enable;
		logic rsv4;
		logic wait_enable;
		logic prox_enable_bit;
		logic rsv1;
		logic power_on_bit;
	} prx_enable_t;

	// retained transfer pointer
	typedef struct packed {
		logic       auto_inc;
		logic [4:0] addr_or_function;
	} prx_ptr_t;

	// system sequencer
	typedef enum logic [3:0] {
		SEQ_SLEEP = 4'b0001,
		SEQ_IDLE  = 4'b0010,
		SEQ_MEAS  = 4'b0100,
		SEQ_WAIT  = 4'b1000
	} prx_seq_t;

	// serial target engine
	typedef enum logic [6:0] {
		TG_IDLE = 7'b0000001,
		TG_ADDR = 7'b0000010,
		TG_ACKA = 7'b0000100,
		TG_WR   = 7'b0001000,
		TG_ACKW = 7'b0010000,
		TG_RD   = 7'b0100000,
		TG_ACKR = 7'b1000000
	} prx_tgt_t;
endpackage : prx_pkg

// >>> core/prx_core.sv
// Functional notes
// - reset initialises state, enters sleep
// - start wakes to idle; no power returns sleep
// - idle until enabled, then measure, then wait
// - cycle repeats while power and prox enabled
// - drive setting picks one of four currents
// - status always updated; pin only when enabled
// - two sixteen-bit range thresholds held
// - out of range: strictly below or above
// - interrupt after configured consecutive misses
// - target address fixed, standard and fast
// - first written byte is the command
// - combined read returns from commanded address
// - bare read uses retained address
// - msb clear first byte: data at pointer
// - command is address or control function
// - write-only pointer, reset zero, top bit select
// - type field: repeat, increment, special
// - special code five clears interrupt
// - reset values for all registers
// - thresholds as low and high bytes
// - result readable low then high byte
// - persistence zero means every measurement
// - sleep after interrupt ends the cycle
// - wait only while wait enable set
// - pin gated by interrupt enable bit
`include "prx_params.svh"
`timescale 1ns/1ns
`default_nettype none
module prx_core #(
	parameter int        WAIT_UNIT_CYC = `PRX_WAIT_UNIT_CYC,
	parameter logic [7:0] PART_CODE    = 8'h5a  // arbitrary value
) (
	// system clock and power-on reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// serial pins
	input  wire logic        i_scl,
	input  wire logic        i_sda_in,
	output logic             o_sda_out,
	output logic             o_sda_oe,
	// interrupt pin, open drain, active low
	output logic             o_int_n_out,
	output logic             o_int_n_oe,
	// front end, oscillator domain
	input  wire logic        i_osc_clk,
	input  wire logic        i_adc_done,
	input  wire logic [15:0] i_adc_data,
	output logic             o_adc_start,
	output logic             o_led_sink_output,
	// static front-end settings
	output logic [7:0]       o_integ_time,
	output logic [1:0]       o_led_drive_level
);
	// ****************************************
	// registers
	// ****************************************
	prx_pkg::prx_enable_t en_reg;     // function enable
	logic [7:0]  itime_reg;           // integration time
	logic [7:0]  wait_interval_reg;           // wait interval
	logic [15:0] low_threshold;       // lower limit
	logic [15:0] high_threshold;      // upper limit
	logic [7:0]  persistence_filter_reg;            // persistence filter
	logic [7:0]  setup_reg;           // wait long setup
	logic [7:0]  pulse_reg;           // pulse total
	logic [7:0]  gain_reg;            // gain control
	logic [7:0]  pulse_duration_reg;          // pulse duration
	logic [7:0]  bias_reg;            // result bias
	logic [15:0] prox_result;         // last result
	logic        irq_flag;            // status interrupt flag
	logic        valid_reg;           // result present
	prx_pkg::prx_ptr_t ptr_reg;       // transfer pointer
	logic [3:0]  persist_count;       // consecutive misses

	// register read mux, used for tx load and ack paths
	function automatic logic [7:0] rd_byte(input logic [4:0] a);
		unique case (a)
			`PRX_A_ENABLE: rd_byte = en_reg;
			`PRX_A_ITIME:  rd_byte = itime_reg;
			`PRX_A_WAIT_INTERVAL:  rd_byte = wait_interval_reg;
			`PRX_A_LOWL:   rd_byte = low_threshold[7:0];
			`PRX_A_LOWH:   rd_byte = low_threshold[15:8];
			`PRX_A_HIGHL:  rd_byte = high_threshold[7:0];
			`PRX_A_HIGHH:  rd_byte = high_threshold[15:8];
			`PRX_A_PERSISTENCE_FILTER:   rd_byte = persistence_filter_reg;
			`PRX_A_SETUP:  rd_byte = setup_reg;
			`PRX_A_PULSE:  rd_byte = pulse_reg;
			`PRX_A_GAIN:   rd_byte = gain_reg;
			`PRX_A_PULSE_DURATION: rd_byte = pulse_duration_reg;
			`PRX_A_PART:   rd_byte = PART_CODE;
			`PRX_A_STATUS: rd_byte = {2'h0, irq_flag, 4'h0, valid_reg};
			`PRX_A_RESL:   rd_byte = prox_result[7:0];
			`PRX_A_RESH:   rd_byte = prox_result[15:8];
			`PRX_A_BIAS:   rd_byte = bias_reg;
			default:       rd_byte = 8'h00;  // unmapped reads zero
		endcase
	endfunction : rd_byte

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] scl_sy;  // [0] first stage only feeds [1]
	logic [2:0] sda_sy;
	// two stages plus one history bit for edges
	always_ff @(posedge i_clk) begin
		scl_sy <= {scl_sy[1:0], i_scl};
		sda_sy <= {sda_sy[1:0], i_sda_in};
	end
	wire scl_rise = scl_sy[1] & ~scl_sy[2];
	wire scl_fall = ~scl_sy[1] & scl_sy[2];
	wire start_det = scl_sy[1] & scl_sy[2] & ~sda_sy[1] & sda_sy[2];
	wire stop_det  = scl_sy[1] & scl_sy[2] & sda_sy[1] & ~sda_sy[2];

	// ****************************************
	// serial target engine
	// ****************************************
	prx_pkg::prx_tgt_t tg_reg;
	logic [3:0] bit_cnt;   // bits seen in this byte
	logic [7:0] shift_reg; // rx or tx byte
	logic       rw_reg;    // read transfer
	logic       first_reg; // next byte is first written
	logic       nack_reg;  // host declined more data

	wire byte_full = (bit_cnt == 4'h8);
	wire wr_done = scl_fall & (tg_reg == prx_pkg::TG_WR) & byte_full;
	// first byte with select set is a command
	wire is_cmd  = first_reg & shift_reg[`PRX_CMD_SEL];
	wire wr_data = wr_done & ~is_cmd;
	wire rd_adv  = scl_rise & (tg_reg == prx_pkg::TG_ACKR);
	wire [7:0] tx_byte = rd_byte(ptr_reg.addr_or_function);

	// sda is only ever pulled low, never driven high
	assign o_sda_out = 1'b0;

	// bit level protocol, one step per scl edge
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tg_reg    <= prx_pkg::TG_IDLE;
			bit_cnt   <= 4'h0;
			shift_reg <= 8'h00;
			rw_reg    <= 1'b0;
			first_reg <= 1'b0;
			nack_reg  <= 1'b0;
			o_sda_oe  <= 1'b0;
		end else if (start_det) begin
			// repeated start also restarts addressing
			tg_reg   <= prx_pkg::TG_ADDR;
			bit_cnt  <= 4'h0;
			o_sda_oe <= 1'b0;
		end else if (stop_det) begin
			tg_reg   <= prx_pkg::TG_IDLE;
			o_sda_oe <= 1'b0;
		end else if (scl_rise) begin
			// sample on rising edge
			if (tg_reg == prx_pkg::TG_ADDR || tg_reg == prx_pkg::TG_WR) begin
				shift_reg <= {shift_reg[6:0], sda_sy[1]};
				bit_cnt   <= bit_cnt + 4'h1;
			end else if (tg_reg == prx_pkg::TG_RD) begin
				bit_cnt <= bit_cnt + 4'h1;
			end else if (tg_reg == prx_pkg::TG_ACKR) begin
				nack_reg <= sda_sy[1];
			end
		end else if (scl_fall) begin
			// change sda only while scl is low
			unique case (tg_reg)
				prx_pkg::TG_ADDR: begin
					// answer only the fixed target address
					if (byte_full && shift_reg[7:1] == `PRX_I2C_ADDR) begin
						tg_reg   <= prx_pkg::TG_ACKA;
						rw_reg   <= shift_reg[0];
						o_sda_oe <= 1'b1;
					end else if (byte_full) begin
						tg_reg <= prx_pkg::TG_IDLE;
					end
				end
				prx_pkg::TG_ACKA: begin
					bit_cnt <= 4'h0;
					if (rw_reg) begin
						// no command needed before a read
						tg_reg    <= prx_pkg::TG_RD;
						shift_reg <= tx_byte;
						o_sda_oe  <= ~tx_byte[7];
					end else begin
						tg_reg    <= prx_pkg::TG_WR;
						first_reg <= 1'b1;
						o_sda_oe  <= 1'b0;
					end
				end
				prx_pkg::TG_WR: begin
					if (byte_full) begin
						tg_reg   <= prx_pkg::TG_ACKW;
						o_sda_oe <= 1'b1;
					end
				end
				prx_pkg::TG_ACKW: begin
					tg_reg    <= prx_pkg::TG_WR;
					bit_cnt   <= 4'h0;
					first_reg <= 1'b0;
					o_sda_oe  <= 1'b0;
				end
				prx_pkg::TG_RD: begin
					if (byte_full) begin
						tg_reg   <= prx_pkg::TG_ACKR;
						o_sda_oe <= 1'b0;
					end else begin
						shift_reg <= {shift_reg[6:0], 1'b0};
						o_sda_oe  <= ~shift_reg[6];
					end
				end
				prx_pkg::TG_ACKR: begin
					// a declined byte ends the read, wait for stop
					if (nack_reg) begin
						tg_reg <= prx_pkg::TG_IDLE;
					end else begin
						tg_reg    <= prx_pkg::TG_RD;
						bit_cnt   <= 4'h0;
						shift_reg <= tx_byte;
						o_sda_oe  <= ~tx_byte[7];
					end
				end
				default: tg_reg <= prx_pkg::TG_IDLE;
			endcase
		end
	end

	// ****************************************
	// command decode and pointer
	// ****************************************
	wire [1:0] cmd_type = shift_reg[6:5];
	// special function code five clears the interrupt
	wire irq_clr = wr_done & is_cmd & (cmd_type == `PRX_TYPE_SF)
		& (shift_reg[4:0] == `PRX_SF_ICLR);

	// pointer keeps last valid addressing command
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ptr_reg <= '0;
		end else if (wr_done && is_cmd) begin
			// reserved type and other functions ignored
			if (cmd_type == `PRX_TYPE_REP || cmd_type == `PRX_TYPE_AUTO) begin
				ptr_reg.auto_inc         <= (cmd_type == `PRX_TYPE_AUTO);
				ptr_reg.addr_or_function <= shift_reg[4:0];
			end
		end else if ((wr_data || rd_adv) && ptr_reg.auto_inc) begin
			ptr_reg.addr_or_function <= ptr_reg.addr_or_function + 5'h1;
		end
	end

	// ****************************************
	// writable registers
	// ****************************************
	// data bytes land at the retained pointer
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			en_reg         <= `PRX_RST_ZERO;
			itime_reg      <= `PRX_RST_TIME;
			wait_interval_reg      <= `PRX_RST_TIME;
			low_threshold  <= 16'h0000;
			high_threshold <= 16'h0000;
			persistence_filter_reg       <= `PRX_RST_ZERO;
			setup_reg      <= `PRX_RST_ZERO;
			pulse_reg      <= `PRX_RST_ZERO;
			gain_reg       <= `PRX_RST_ZERO;
			pulse_duration_reg     <= `PRX_RST_ZERO;
			bias_reg       <= `PRX_RST_ZERO;
		end else if (wr_data) begin
			// read-only and unmapped writes are dropped
			unique case (ptr_reg.addr_or_function)
				`PRX_A_ENABLE: en_reg <= shift_reg;
				`PRX_A_ITIME:  itime_reg <= shift_reg;
				`PRX_A_WAIT_INTERVAL:  wait_interval_reg <= shift_reg;
				`PRX_A_LOWL:   low_threshold[7:0] <= shift_reg;
				`PRX_A_LOWH:   low_threshold[15:8] <= shift_reg;
				`PRX_A_HIGHL:  high_threshold[7:0] <= shift_reg;
				`PRX_A_HIGHH:  high_threshold[15:8] <= shift_reg;
				`PRX_A_PERSISTENCE_FILTER:   persistence_filter_reg <= shift_reg;
				`PRX_A_SETUP:  setup_reg <= shift_reg;
				`PRX_A_PULSE:  pulse_reg <= shift_reg;
				`PRX_A_GAIN:   gain_reg <= shift_reg;
				`PRX_A_PULSE_DURATION: pulse_duration_reg <= shift_reg;
				`PRX_A_BIAS:   bias_reg <= shift_reg;
				default: ;
			endcase
		end
	end

	// two-bit drive level selects four sink currents
	assign o_led_drive_level = gain_reg[`PRX_DRIVE_MSB:`PRX_DRIVE_LSB];
	assign o_integ_time      = itime_reg;

	// ****************************************
	// front-end crossing
	// ****************************************
	logic       req_tgl;     // main: new measurement
	logic [2:0] ack_sy;      // main: ack toggle sync
	logic [1:0] orst_sy;     // osc: reset sync
	logic [2:0] req_sy;      // osc: request sync
	logic       ack_tgl;     // osc: result ready
	logic       fe_busy;     // osc: measuring
	logic [15:0] hold_reg;   // osc: result, stable at toggle
	wire osc_rst = orst_sy[1];

	// reset and request into oscillator domain
	always_ff @(posedge i_osc_clk) begin
		orst_sy <= {orst_sy[0], i_rst};
		req_sy  <= {req_sy[1:0], req_tgl};
	end

	// one measurement per request toggle
	always_ff @(posedge i_osc_clk) begin
		if (osc_rst) begin
			fe_busy     <= 1'b0;
			ack_tgl     <= 1'b0;
			hold_reg    <= 16'h0000;
			o_adc_start <= 1'b0;
		end else begin
			o_adc_start <= (req_sy[1] != req_sy[2]);
			if (req_sy[1] != req_sy[2]) begin
				fe_busy <= 1'b1;
			end else if (fe_busy && i_adc_done) begin
				// data held until the next conversion completes
				hold_reg <= i_adc_data;
				ack_tgl  <= ~ack_tgl;
				fe_busy  <= 1'b0;
			end
		end
	end
	assign o_led_sink_output = fe_busy;

	// acknowledge back into main domain
	always_ff @(posedge i_clk) begin
		ack_sy <= {ack_sy[1:0], ack_tgl};
	end
	wire meas_done = ack_sy[1] ^ ack_sy[2];

	// ****************************************
	// result and interrupt filter
	// ****************************************
	// strictly outside the window
	wire out_rng = (hold_reg < low_threshold) | (hold_reg > high_threshold);
	wire [3:0] persist_cfg = persistence_filter_reg[7:4];
	wire [3:0] cnt_next = (persist_count == 4'hf) ? 4'hf : persist_count + 4'h1;
	// zero setting fires on every measurement
	wire irq_event = meas_done & ((persist_cfg == 4'h0)
		| (out_rng & (cnt_next >= persist_cfg)));

	// result captured when the front end answers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			prox_result <= 16'h0000;
			valid_reg   <= 1'b0;
		end else if (meas_done) begin
			prox_result <= hold_reg;
			valid_reg   <= 1'b1;
		end
	end

	// miss counter cleared in range and by clear
	always_ff @(posedge i_clk) begin
		if (i_rst || irq_clr) begin
			persist_count <= 4'h0;
		end else if (meas_done) begin
			persist_count <= out_rng ? cnt_next : 4'h0;
		end
	end

	// flag tracks events regardless of enable
	// clear drops the flag; a same-cycle event wins
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_flag <= 1'b0;
		end else if (irq_event) begin
			irq_flag <= 1'b1;
		end else if (irq_clr) begin
			irq_flag <= 1'b0;
		end
	end

	// pin pulled low only with interrupt enable
	assign o_int_n_out = 1'b0;
	assign o_int_n_oe  = irq_flag & en_reg.prox_irq_enable;

	// ****************************************
	// system sequencer and wait timer
	// ****************************************
	prx_pkg::prx_seq_t seq_reg;
	logic [11:0] step_cnt;   // wait units left
	logic [23:0] unit_cnt;   // cycles left in one unit
	wire sleep_hold = en_reg.sleep_after_irq & irq_flag;
	wire go_meas = en_reg.power_on_bit & en_reg.prox_enable_bit & ~sleep_hold;
	wire [8:0]  wait_units = 9'h100 - {1'b0, wait_interval_reg};
	wire [11:0] wait_steps = setup_reg[`PRX_WLONG]
		? 12'(wait_units * `PRX_WLONG_MULT) : {3'h0, wait_units};
	wire wait_end = (step_cnt == 12'h0) & (unit_cnt == 24'h0);

	// state transitions
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			seq_reg <= prx_pkg::SEQ_SLEEP;
		end else begin
			unique case (seq_reg)
				prx_pkg::SEQ_SLEEP: begin
					if (start_det) seq_reg <= prx_pkg::SEQ_IDLE;
				end
				prx_pkg::SEQ_IDLE: begin
					// start a new cycle while enabled
					if (!en_reg.power_on_bit) seq_reg <= prx_pkg::SEQ_SLEEP;
					else if (go_meas) seq_reg <= prx_pkg::SEQ_MEAS;
				end
				prx_pkg::SEQ_MEAS: begin
					if (meas_done) begin
						// interrupt with sleep-after set powers down
						// wait skipped when wait is disabled
						if (en_reg.sleep_after_irq && (irq_event || irq_flag))
							seq_reg <= prx_pkg::SEQ_SLEEP;
						else if (en_reg.wait_enable)
							seq_reg <= prx_pkg::SEQ_WAIT;
						else
							seq_reg <= prx_pkg::SEQ_IDLE;
					end
				end
				prx_pkg::SEQ_WAIT: begin
					if (wait_end || !en_reg.wait_enable) seq_reg <= prx_pkg::SEQ_IDLE;
				end
				default: seq_reg <= prx_pkg::SEQ_SLEEP;
			endcase
		end
	end

	// request toggles once per idle-to-measure step
	always_ff @(posedge i_clk) begin
		if (i_rst) req_tgl <= 1'b0;
		else if (seq_reg == prx_pkg::SEQ_IDLE && go_meas) req_tgl <= ~req_tgl;
	end

	// timer loaded at measure end, runs only in wait
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			step_cnt <= 12'h0;
			unit_cnt <= 24'h0;
		end else if (seq_reg == prx_pkg::SEQ_MEAS) begin
			step_cnt <= wait_steps - 12'h1;
			unit_cnt <= 24'(WAIT_UNIT_CYC - 1);
		end else if (seq_reg == prx_pkg::SEQ_WAIT && !wait_end) begin
			if (unit_cnt == 24'h0) begin
				step_cnt <= step_cnt - 12'h1;
				unit_cnt <= 24'(WAIT_UNIT_CYC - 1);
			end else begin
				unit_cnt <= unit_cnt - 24'h1;
			end
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_addr_byte;
		tg_reg == prx_pkg::TG_ADDR && byte_full && scl_fall && !start_det && !stop_det;
	endsequence

	a_reset_sleep: assert property (disable iff (1'b0) i_rst |=> seq_reg == prx_pkg::SEQ_SLEEP)
		else $error("sequencer not asleep after reset");
	a_nopower_sleep: assert property (seq_reg == prx_pkg::SEQ_IDLE && !en_reg.power_on_bit
		|=> seq_reg == prx_pkg::SEQ_SLEEP) else $error("idle without power stayed awake");
	a_idle_to_meas: assert property (seq_reg == prx_pkg::SEQ_IDLE && go_meas
		|=> seq_reg == prx_pkg::SEQ_MEAS ##0 $changed(req_tgl)) else $error("no measurement");
	a_wait_skip: assert property (seq_reg == prx_pkg::SEQ_MEAS && meas_done
		&& !en_reg.wait_enable && !en_reg.sleep_after_irq |=> seq_reg == prx_pkg::SEQ_IDLE)
		else $error("wait not skipped");
	a_addr_ack: assert property (s_addr_byte ##0 shift_reg[7:1] == `PRX_I2C_ADDR
		|=> o_sda_oe && tg_reg == prx_pkg::TG_ACKA) else $error("own address not acked");
	a_addr_other: assert property (s_addr_byte ##0 shift_reg[7:1] != `PRX_I2C_ADDR
		|=> !o_sda_oe [*2]) else $error("foreign address acked");
	a_auto_inc: assert property (wr_data && ptr_reg.auto_inc
		|=> ptr_reg.addr_or_function == $past(ptr_reg.addr_or_function) + 5'h1)
		else $error("pointer not advanced");
	a_repeat_fixed: assert property (wr_data && !ptr_reg.auto_inc
		|=> $stable(ptr_reg)) else $error("pointer moved in repeat mode");
	a_every_meas: assert property (meas_done && persist_cfg == 4'h0
		|=> irq_flag) else $error("zero persistence did not fire");
	a_range_reset: assert property (meas_done && !out_rng && !irq_clr
		|=> persist_count == 4'h0) else $error("miss counter kept in range");
	a_clear_pin: assert property (irq_clr && !irq_event
		|=> !irq_flag && !o_int_n_oe) else $error("clear did not release pin");
	a_pin_gate: assert property (!en_reg.prox_irq_enable |-> !o_int_n_oe)
		else $error("pin driven while disabled");
	a_fe_done: assert property (@(posedge i_osc_clk) disable iff (osc_rst)
		fe_busy && i_adc_done && req_sy[1] == req_sy[2] |=> !fe_busy ##0 $changed(ack_tgl))
		else $error("front end answer lost");
endmodule : prx_core
`default_nettype wire

// >>> test/prx_host.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// serial host model, moves just after i_clk
// ****************************************
module prx_host (
	// clock and data wire level
	input  wire logic i_clk,
	input  wire logic i_sda,
	// host pins
	output logic      o_scl,
	output logic      o_sda_oe
);
	// bus idle: both lines released
	initial begin
		o_scl    = 1'b1;
		o_sda_oe = 1'b0;
	end
	// wait edges, then step off the edge
	task wt(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : wt
	// start or repeated start, scl left low
	task start();
		o_sda_oe = 1'b0;
		wt(5);
		o_scl = 1'b1;
		wt(5);
		o_sda_oe = 1'b1;
		wt(5);
		o_scl = 1'b0;
		wt(2);
	endtask : start
	// stop: data rises while clock high
	task stop();
		o_sda_oe = 1'b1;
		wt(5);
		o_scl = 1'b1;
		wt(5);
		o_sda_oe = 1'b0;
		wt(8);
	endtask : stop
	// byte then ack bit, msb first
	task xfer(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic r);
		logic [8:0] v;
		v = {d, ab};
		for (int i = 8; i >= 0; i--) begin
			// data only changes while clock low
			o_sda_oe = ~v[i];
			wt(5);
			o_scl = 1'b1;
			wt(3);
			v[i] = i_sda;
			wt(2);
			o_scl = 1'b0;
		end
		o_sda_oe = 1'b0;
		q = v[8:1];
		r = v[0];
	endtask : xfer
endmodule : prx_host
`default_nettype wire

// >>> test/proximity_sensor_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module proximity_sensor_control_tb_top;
	logic clk = 0, rst = 1, osc = 0, adc_done = 0, scl, h_oe, sda_oe, sda_out, int_oe, int_out;
	logic adc_start, led;
	logic [15:0] adc_data = 16'h0050;
	logic [7:0]  itime, q;
	logic [1:0]  drive;
	logic [3:0]  sh = 4'h0;
	logic        r;
	int          err_total = 0, compares = 0, ndone = 0;
	// address rows: {command, expected reset value}
	logic [15:0] rows [17] = '{16'h8000, 16'h8100, 16'h82ff, 16'h83ff, 16'h8800, 16'h8900,
		16'h8a00, 16'h8b00, 16'h8c00, 16'h8d00, 16'h8e00, 16'h8f00, 16'h9000, 16'h9300,
		16'h9800, 16'h9900, 16'h9e00};
	// open-drain data wire with pull-up
	wire logic sda = ~(h_oe | sda_oe);
	always #20 clk = ~clk;
	initial forever #80 osc = ~osc;
	// front end answers five osc cycles after start
	always @(posedge osc) begin
		sh <= {sh[2:0], adc_start};
		adc_done <= sh[3];
		if (sh[3]) ndone <= ndone + 1;
	end
	prx_host u_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));
	prx_core #(.WAIT_UNIT_CYC(4)) u_dut (.i_clk(clk), .i_rst(rst), .i_scl(scl),
		.i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_int_n_out(int_out),
		.o_int_n_oe(int_oe), .i_osc_clk(osc), .i_adc_done(adc_done), .i_adc_data(adc_data),
		.o_adc_start(adc_start), .o_led_sink_output(led), .o_integ_time(itime),
		.o_led_drive_level(drive));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// write: command then n data bytes
	task wr(input logic [7:0] c, input logic [7:0] d0, input logic [7:0] d1, input int n);
		u_host.start();
		u_host.xfer(8'h72, 1'b1, q, r);
		u_host.xfer(c, 1'b1, q, r);
		if (n > 0) u_host.xfer(d0, 1'b1, q, r);
		if (n > 1) u_host.xfer(d1, 1'b1, q, r);
		u_host.stop();
	endtask : wr
	// read one byte; command 00 means bare read
	task rd(input logic [7:0] c, input logic [7:0] exp);
		if (c[7]) begin
			u_host.start();
			u_host.xfer(8'h72, 1'b1, q, r);
			u_host.xfer(c, 1'b1, q, r);
		end
		u_host.start();
		u_host.xfer(8'h73, 1'b1, q, r);
		u_host.xfer(8'hff, 1'b1, q, r);
		u_host.stop();
		chk(q, exp);
	endtask : rd
	// wait for n more conversions, bounded
	task wdone(input int n);
		int t;
		t = ndone + n;
		for (int k = 0; k < 5000 && ndone < t; k++) @(posedge clk);
		repeat (10) @(posedge clk);
		#1;
	endtask : wdone
	task finish_test();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	initial begin
		#3000000;
		err_total++;
		finish_test();
	end
	initial begin
		repeat (12) @(posedge clk);
		#1 rst = 0;
		u_host.wt(3);
		chk(itime, 8'hff);
		chk({5'h0, drive, int_oe}, 8'h00);
		foreach (rows[i]) rd(rows[i][15:8], rows[i][7:0]);
		chk(ndone[7:0], 8'h00);
		wr(8'h8f, 8'hc0, 8'h00, 1);
		chk({6'h0, drive}, 8'h03);
		wr(8'ha8, 8'h11, 8'h22, 2);
		rd(8'h88, 8'h11);
		rd(8'h89, 8'h22);
		wr(8'h8a, 8'h33, 8'h44, 2);
		rd(8'h8a, 8'h44);
		rd(8'h8b, 8'h00);
		wr(8'h98, 8'h77, 8'h00, 1);
		rd(8'h98, 8'h00);
		wr(8'h9e, 8'h00, 8'h00, 0);
		wr(8'h5a, 8'h5a, 8'h00, 1);
		rd(8'h00, 8'h5a);
		u_host.start();
		u_host.xfer(8'h74, 1'b1, q, r);
		u_host.stop();
		chk({7'h0, r}, 8'h01);
		wr(8'ha8, 8'h00, 8'h01, 2);
		wr(8'haa, 8'h00, 8'h02, 2);
		wr(8'h8c, 8'h20, 8'h00, 1);
		wr(8'h83, 8'h00, 8'h00, 1);
		wr(8'h80, 8'h2d, 8'h00, 1);
		u_host.start();
		wdone(1);
		u_host.stop();
		chk({7'h0, int_oe}, 8'h00);
		wdone(2);
		chk({7'h0, int_oe}, 8'h01);
		rd(8'h93, 8'h21);
		rd(8'h98, 8'h50);
		rd(8'h00, 8'h50);
		adc_data = 16'h0100;
		wdone(2);
		wr(8'he5, 8'h00, 8'h00, 0);
		chk({7'h0, int_oe}, 8'h00);
		rd(8'h93, 8'h01);
		adc_data = 16'h0201;
		wr(8'h80, 8'h05, 8'h00, 1);
		wdone(3);
		chk({7'h0, int_oe}, 8'h00);
		rd(8'h93, 8'h21);
		finish_test();
	end
endmodule : proximity_sensor_control_tb_top
`default_nettype wire
